/* File: include/gpio_pkg.sv */
// package: constants and carrier types for the eight-port gpio block
package gpio_pkg;
    localparam int PIN_WIDTH = 8;
    localparam int PORT_COUNT = 8;
    localparam int MASK_LSB = 2; // address bits 9:2 are the lane mask
    localparam int ADDR_WIDTH = 10;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    // reset values per port; debug pins are port b bit 7, port c bits 3:0
    localparam logic [7:0] ORDINARY_RESET = 8'h00;
    localparam logic [7:0] PORT_B_DEBUG_BITS = 8'h80;
    localparam logic [7:0] PORT_C_DEBUG_BITS = 8'h0F;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // pad configuration of one port
    typedef struct packed {
        logic [7:0] altFunctionSelect;
        logic [7:0] padDigitalEnable;
        logic [7:0] padPullDownCtl;
        logic [7:0] padPullUpCtl;
    } pad_cfg_type;

    // register access of one port
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic dirWrEn;
        logic cfgWrEn;
        logic [9:0] addr;
        logic [7:0] wdata;
        pad_cfg_type cfgData;
    } port_req_type;

    // pin side of one port
    typedef struct packed {
        logic [7:0] pinOut;
        logic [7:0] pinOe;
    } pin_drive_type;

    // debug default mask of a given port
    function automatic logic [7:0] debugBits(input int port);
        debugBits = (port == PORT_B) ? PORT_B_DEBUG_BITS :
                    (port == PORT_C) ? PORT_C_DEBUG_BITS : ORDINARY_RESET;
    endfunction
endpackage

/* File: hdl/pin_value_reg.sv */
// module: masked data register and direction register of one port
`timescale 1ns/1ps
module pin_value_reg #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic wrEn,
    input wire logic dirWrEn,
    input wire logic [9:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] afsel,
    output logic [WIDTH-1:0] pinValue,
    output logic [WIDTH-1:0] pinDirection
);
    logic [WIDTH-1:0] value_ff;
    logic [WIDTH-1:0] dir_ff;
    logic [WIDTH-1:0] nxt_value;
    logic [WIDTH-1:0] mask;

    assign mask = addr[gpio_pkg::MASK_LSB +: WIDTH];
    assign pinValue = value_ff;
    assign pinDirection = dir_ff;

    // per bit: inputs without alternate select capture the pin, other bits take masked writes
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (!dir_ff[i] && !afsel[i])
                nxt_value[i] = pinIn[i];
            else if (wrEn && mask[i])
                nxt_value[i] = wdata[i];
            else
                nxt_value[i] = value_ff[i];
        end
    end

    // data storage
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            value_ff <= gpio_pkg::DATA_RESET;
        else
            value_ff <= nxt_value;
    end

    // direction, all inputs after reset
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            dir_ff <= gpio_pkg::DIRECTION_RESET;
        else if (dirWrEn)
            dir_ff <= wdata;
    end
endmodule // pin_value_reg

/* File: hdl/gpio_port.sv */
// module: one gpio port with pad configuration and pin drive
`timescale 1ns/1ps
module gpio_port #(
    parameter int PORT_INDEX = 0
) (
    input wire logic clock,
    input wire logic nrst,
    input wire gpio_pkg::port_req_type req,
    input wire logic [7:0] pinIn,
    input wire logic [7:0] altOut,
    input wire logic [7:0] altOe,
    output gpio_pkg::pin_drive_type drive_ff,
    output gpio_pkg::pad_cfg_type cfg_ff,
    output logic [7:0] rdata_ff,
    output logic [7:0] direction
);
    localparam logic [7:0] DBG = gpio_pkg::debugBits(PORT_INDEX);
    logic [7:0] value;
    logic [7:0] mask;

    assign mask = req.addr[gpio_pkg::MASK_LSB +: 8];

    pin_value_reg #(.WIDTH(8)) u_data (
        .clock(clock),
        .nrst(nrst),
        .wrEn(req.wrEn),
        .dirWrEn(req.dirWrEn),
        .addr(req.addr),
        .wdata(req.wdata),
        .pinIn(pinIn),
        .afsel(cfg_ff.altFunctionSelect),
        .pinValue(value),
        .pinDirection(direction)
    );

    // pad configuration, debug pins default on
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_ff.altFunctionSelect <= DBG;
            cfg_ff.padDigitalEnable <= DBG;
            cfg_ff.padPullDownCtl <= gpio_pkg::ORDINARY_RESET;
            cfg_ff.padPullUpCtl <= DBG;
        end
        else if (req.cfgWrEn)
            cfg_ff <= req.cfgData;
    end

    // pin drive: peripheral wins over gpio when selected
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            drive_ff.pinOut <= 8'h00;
            drive_ff.pinOe <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (cfg_ff.altFunctionSelect[i])
                begin
                    drive_ff.pinOut[i] <= altOut[i];
                    drive_ff.pinOe[i] <= altOe[i] & cfg_ff.padDigitalEnable[i];
                end
                else
                begin
                    drive_ff.pinOut[i] <= value[i];
                    drive_ff.pinOe[i] <= direction[i] & cfg_ff.padDigitalEnable[i];
                end
            end
        end
    end

    // masked read data
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdata_ff <= 8'h00;
        else if (req.rdEn)
            rdata_ff <= value & mask;
    end

    // masked write checks: unmasked held bits stay, masked held bits take the data
    property p_write_masked;
        @(posedge clock) disable iff (!nrst)
        req.wrEn |=> (((value ^ $past(value)) & ~$past(mask) & ($past(direction) | $past(cfg_ff.altFunctionSelect)))
            == 8'h00);
    endproperty
    a_write_masked: assert property (p_write_masked) else $error("unmasked bit changed");
    property p_write_lands;
        @(posedge clock) disable iff (!nrst)
        req.wrEn |=> (((value ^ $past(req.wdata)) & $past(mask) & ($past(direction) | $past(cfg_ff.altFunctionSelect)))
            == 8'h00);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("masked bit not written");

    // masked read checks
    property p_read_masked;
        @(posedge clock) disable iff (!nrst)
        req.rdEn |=> ((rdata_ff & ~$past(mask)) == 8'h00);
    endproperty
    a_read_masked: assert property (p_read_masked) else $error("masked read bit not zero");
    property p_read_value;
        @(posedge clock) disable iff (!nrst)
        req.rdEn |=> (rdata_ff == ($past(value) & $past(mask)));
    endproperty
    a_read_value: assert property (p_read_value) else $error("read value wrong");

    // input pins: captured, never driven
    property p_input_capture;
        @(posedge clock) disable iff (!nrst)
        (!direction[0] && !cfg_ff.altFunctionSelect[0] && !req.dirWrEn && !req.cfgWrEn)
        |=> (value[0] == $past(pinIn[0]));
    endproperty
    a_input_capture: assert property (p_input_capture) else $error("input not captured");
    property p_input_undriven;
        @(posedge clock) disable iff (!nrst)
        (!direction[3] && !cfg_ff.altFunctionSelect[3]) |=> !drive_ff.pinOe[3];
    endproperty
    a_input_undriven: assert property (p_input_undriven) else $error("input pin driven");

    // output and peripheral drive
    property p_output_drive;
        @(posedge clock) disable iff (!nrst)
        (direction[1] && !cfg_ff.altFunctionSelect[1] && cfg_ff.padDigitalEnable[1])
        |=> (drive_ff.pinOe[1] && drive_ff.pinOut[1] == $past(value[1]));
    endproperty
    a_output_drive: assert property (p_output_drive) else $error("output not driven");
    property p_alt_drive;
        @(posedge clock) disable iff (!nrst)
        cfg_ff.altFunctionSelect[2] |=> (drive_ff.pinOut[2] == $past(altOut[2]));
    endproperty
    a_alt_drive: assert property (p_alt_drive) else $error("alt function ignored");
    property p_alt_enable;
        @(posedge clock) disable iff (!nrst)
        cfg_ff.altFunctionSelect[2]
        |=> (drive_ff.pinOe[2] == ($past(altOe[2]) & $past(cfg_ff.padDigitalEnable[2])));
    endproperty
    a_alt_enable: assert property (p_alt_enable) else $error("alt enable ignored");

    // direction writes and reset defaults
    property p_dir_write;
        @(posedge clock) disable iff (!nrst)
        req.dirWrEn |=> (direction == $past(req.wdata));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");
    property p_cfg_reset;
        @(posedge clock)
        $rose(nrst) |-> (cfg_ff == {DBG, DBG, gpio_pkg::ORDINARY_RESET, DBG});
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("pad defaults wrong");
    property p_dir_reset;
        @(posedge clock)
        $rose(nrst) |-> (direction == gpio_pkg::DIRECTION_RESET);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not reset");
    c_masked_write: cover property (@(posedge clock) disable iff (!nrst) req.wrEn && mask != 8'hFF);
    c_masked_read: cover property (@(posedge clock) disable iff (!nrst) req.rdEn && mask == 8'h31);
    c_alt_mode: cover property (@(posedge clock) disable iff (!nrst) cfg_ff.altFunctionSelect != DBG);
endmodule // gpio_port

/* File: hdl/gpio_ports_top.sv */
// top: eight gpio ports of one module, debug defaults on ports b and c, behind plain control ports
`timescale 1ns/1ps
// Functional notes
// - non-debug pins reset tristated, all pad controls clear
// - debug pins reset to debug function, pulled up
// - any reset restores both pin groups' defaults
// - port b bit 7 returns as test reset
// - eight separate port instances, alike but for the debug reset defaults of ports b and c
// - direction zero and alternate select clear: data bit captures pin level
// - direction one: data bit drives the pin when its pad digital enable is set
// - address bits 9:2 mask data bits 7:0
// - writes change only bits with mask one
// - reads return zero where mask is zero
// - alternate select hands pin to peripheral
module gpio_ports_top #(
    parameter int PORTS = gpio_pkg::PORT_COUNT
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [PORTS-1:0] portSelect,
    input wire logic dataWrite,
    input wire logic dataRead,
    input wire logic directionWrite,
    input wire logic padConfigWrite,
    input wire logic [9:0] address,
    input wire logic [7:0] writeData,
    input wire gpio_pkg::pad_cfg_type padConfigIn,
    input wire logic [PORTS*8-1:0] pinIn,
    input wire logic [PORTS*8-1:0] altOut,
    input wire logic [PORTS*8-1:0] altOe,
    output logic [PORTS*8-1:0] pinOut,
    output logic [PORTS*8-1:0] pinOe,
    output logic [PORTS*32-1:0] padConfig,
    output logic [7:0] readData
);
    logic [7:0] rdata [PORTS];
    logic [PORTS-1:0] rdSel_ff;
    logic [7:0] nxt_readData;
    logic [7:0] readData_ff;

    // one instance per port
    generate
        for (genvar p = 0; p < PORTS; p++)
        begin : g_port
            gpio_pkg::port_req_type req;
            gpio_pkg::pin_drive_type drive;
            gpio_pkg::pad_cfg_type cfg;
            assign req.wrEn = dataWrite & portSelect[p];
            assign req.rdEn = dataRead & portSelect[p];
            assign req.dirWrEn = directionWrite & portSelect[p];
            assign req.cfgWrEn = padConfigWrite & portSelect[p];
            assign req.addr = address;
            assign req.wdata = writeData;
            assign req.cfgData = padConfigIn;
            gpio_port #(.PORT_INDEX(p)) u_port (
                .clock(clock),
                .nrst(nrst),
                .req(req),
                .pinIn(pinIn[p*8 +: 8]),
                .altOut(altOut[p*8 +: 8]),
                .altOe(altOe[p*8 +: 8]),
                .drive_ff(drive),
                .cfg_ff(cfg),
                .rdata_ff(rdata[p]),
                .direction()
            );
            assign pinOut[p*8 +: 8] = drive.pinOut;
            assign pinOe[p*8 +: 8] = drive.pinOe;
            assign padConfig[p*32 +: 32] = cfg;
        end
    endgenerate

    // remember which port was read
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdSel_ff <= '0;
        else if (dataRead)
            rdSel_ff <= portSelect;
    end

    // or together the selected port's read bytes
    always_comb
    begin
        nxt_readData = 8'h00;
        for (int p = 0; p < PORTS; p++)
            if (rdSel_ff[p])
                nxt_readData = nxt_readData | rdata[p];
    end

    // registered read byte, one edge after the port answer
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            readData_ff <= 8'h00;
        else
            readData_ff <= nxt_readData;
    end
    assign readData = readData_ff;

    // reset defaults of the debug pins and of the pin output enables
    property p_debug_reset;
        @(posedge clock)
        $rose(nrst) |-> (padConfig[gpio_pkg::PORT_B*32 + 31] && padConfig[gpio_pkg::PORT_B*32 + 7]);
    endproperty
    a_debug_reset: assert property (p_debug_reset) else $error("test reset pin not defaulted");
    property p_debug_c_reset;
        @(posedge clock)
        $rose(nrst) |-> (padConfig[gpio_pkg::PORT_C*32 +: 32] == {gpio_pkg::PORT_C_DEBUG_BITS,
            gpio_pkg::PORT_C_DEBUG_BITS, gpio_pkg::ORDINARY_RESET, gpio_pkg::PORT_C_DEBUG_BITS});
    endproperty
    a_debug_c_reset: assert property (p_debug_c_reset) else $error("debug pad defaults wrong");
    property p_tristate_reset;
        @(posedge clock)
        $rose(nrst) |-> (pinOe == '0);
    endproperty
    a_tristate_reset: assert property (p_tristate_reset) else $error("pin driven after reset");

    // read byte shows zero in masked lanes
    property p_read_zero;
        @(posedge clock) disable iff (!nrst)
        dataRead |-> ##2 ((readData & ~$past(address[gpio_pkg::MASK_LSB +: 8], 2)) == 8'h00);
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("masked lane read not zero");
    c_reset_seen: cover property (@(posedge clock) $rose(nrst));
endmodule // gpio_ports_top

/* File: verif/gpio_pin_model.sv */
// pin-side partner: outside levels meeting the device drive
`timescale 1ns/1ps
module gpio_pin_model (
    input wire logic nrst,
    input wire logic [63:0] pinOut,
    input wire logic [63:0] pinOe,
    input wire logic [63:0] extLevel,
    output logic [63:0] pinIn
);
    // driven pins show the device, released pins the outside level; pin 15 is held high during reset
    always_comb
    begin
        pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
        if (!nrst)
            pinIn[15] = 1'b1;
    end
endmodule // gpio_pin_model

/* File: verif/test_gpio_port_data_control.sv */
// testbench: eight gpio ports driven through plain control ports
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin nErrors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module test_gpio_port_data_control;
    logic clock, nrst, dataWrite, dataRead, directionWrite, padConfigWrite, rdPend, rdLate;
    logic [7:0] portSelect, writeData, readData, got;
    logic [9:0] address;
    gpio_pkg::pad_cfg_type padConfigIn;
    logic [63:0] pinIn, altOut, altOe, extLevel, pinOut, pinOe;
    logic [255:0] padConfig;
    logic [7:0] expData [8];
    logic [7:0] expQ [$];
    logic [9:0] a;
    logic [31:0] w;
    int nErrors, comparisons, seed, p;

    gpio_ports_top dut_u (.clock(clock), .nrst(nrst), .portSelect(portSelect), .dataWrite(dataWrite),
        .dataRead(dataRead), .directionWrite(directionWrite), .padConfigWrite(padConfigWrite),
        .address(address), .writeData(writeData), .padConfigIn(padConfigIn), .pinIn(pinIn),
        .altOut(altOut), .altOe(altOe), .pinOut(pinOut), .pinOe(pinOe), .padConfig(padConfig),
        .readData(readData));
    gpio_pin_model pins_u (.nrst(nrst), .pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        nErrors++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////
    // one strobe per call, held for exactly one rising edge
    task automatic op(input int q, input int k, input logic [9:0] ad, input logic [31:0] d);
        @(negedge clock);
        portSelect <= 8'h01 << q;
        dataWrite <= (k == 0);
        dataRead <= (k == 1);
        directionWrite <= (k == 2);
        padConfigWrite <= (k == 3);
        address <= ad;
        writeData <= d[7:0];
        padConfigIn <= d;
    endtask
    task automatic idle(input int n);
        @(negedge clock);
        {dataWrite, dataRead, directionWrite, padConfigWrite} <= 4'h0;
        repeat (n) @(negedge clock);
    endtask
    // read request; expected masked value noted in the queue
    task automatic rd(input int q, input logic [9:0] ad);
        op(q, 1, ad, 32'h0);
        expQ.push_back(expData[q] & ad[9:2]);
    endtask
    task automatic doReset;
        idle(1);
        nrst <= 1'b0;
        repeat (10) @(negedge clock);
        nrst <= 1'b1;
        idle(1);
        for (int q = 0; q < 8; q++)
        begin
            `CHK(padConfig[q*32+:32], (q == 1) ? 32'h8080_0080 : (q == 2) ? 32'h0F0F_000F : 32'h0)
        end
        `CHK(pinOe, 64'h0)
    endtask
    task summarize;
        $display("errors %0d comparisons %0d", nErrors, comparisons);
        if (nErrors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // read monitor: oldest note against the registered answer two edges on
    always @(posedge clock)
    begin
        rdPend <= dataRead & nrst;
        rdLate <= rdPend & nrst;
    end
    always @(negedge clock)
    begin
        if (rdLate)
        begin
            got = expQ.pop_front();
            `CHK(readData, got)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        seed = 78756;
        {nrst, portSelect, dataWrite, dataRead, directionWrite, padConfigWrite} = '0;
        {address, writeData, padConfigIn, altOut, altOe, extLevel, nErrors, comparisons} = '0;
        doReset();
        // all ports digital outputs, then random masked writes and reads
        for (int q = 0; q < 8; q++)
        begin
            op(q, 3, 10'h0, 32'h00FF_0000);
            op(q, 2, 10'h0, 32'hFF);
            expData[q] = 8'h00;
        end
        for (int i = 0; i < 40; i++)
        begin
            p = $random(seed) & 7;
            a = $random(seed);
            w = $random(seed);
            op(p, 0, a, w);
            expData[p] = (expData[p] & ~a[9:2]) | (w[7:0] & a[9:2]);
            rd($random(seed) & 7, $random(seed));
        end
        idle(2);
        for (int q = 0; q < 8; q++)
        begin
            `CHK(pinOut[q*8+:8], expData[q])
            rd(q, 10'h3FC);
            rd(q, 10'h000);
        end
        `CHK(pinOe, {8{8'hFF}})
        // inputs: data register follows the outside level
        for (int q = 0; q < 8; q++)
            op(q, 2, 10'h0, 32'h0);
        extLevel <= {$random(seed), $random(seed)};
        idle(3);
        `CHK(pinOe, 64'h0)
        for (int q = 0; q < 8; q++)
        begin
            expData[q] = extLevel[q*8+:8];
            rd(q, 10'h3FC);
        end
        // alternate function hands port 3 to the peripheral
        op(3, 3, 10'h0, 32'hFFFF_0000);
        altOut <= {$random(seed), $random(seed)};
        altOe <= {$random(seed), $random(seed)};
        idle(3);
        `CHK(pinOut[31:24], altOut[31:24])
        `CHK(pinOe[31:24], altOe[31:24])
        altOe <= 64'h0;
        // mid-run reset restores both pin groups
        doReset();
        summarize();
    end
endmodule // test_gpio_port_data_control
